// >>> dv/stpwm_checker.sv
// Port checker for the standard timer block.
// Assumes a bind to stpwm_timer; configuration is shadowed from APB writes.
`timescale 1ns/100ps
`include "stpwm_consts.svh"
module stpwm_checker
  import stpwm_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int P_W   = 8
) (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [`STPWM_ADDR_W-1:0] paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire logic                     timer_tick,
  input wire logic                     ext_clock_trigger_pin,
  input wire logic                     capture_input_pin,
  input wire logic                     pulse_out,
  input wire logic                     pulse_out_en_n,
  input wire logic                     timer_irq
);
  logic [7:0]       cfg_r;
  logic [CNT_W-1:0] cmpa_r;
  logic [CNT_W:0]   act_cnt_r;
  logic [1:0]       age_r;
  logic             on_r;
  logic             wr;
  logic             act;
  logic             pwm;
  logic             sp;
  logic             cap;
  logic             mapped;
  assign wr     = psel & penable & pwrite & pready;
  assign act    = cfg_r[`STPWM_CFG_LEVEL_BIT] ^ cfg_r[`STPWM_CFG_INV_BIT];
  assign pwm    = age_r[1] && cfg_r[7:6] == STPWM_MODE_PWM;
  assign sp     = pwm && cfg_r[5:4] == STPWM_PIN_11;
  assign cap    = age_r[1] && cfg_r[7:6] == STPWM_MODE_CAPTURE;
  assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r     <= `STPWM_RST_CFG;
      cmpa_r    <= '0;
      on_r      <= 1'b0;
      age_r     <= 2'd0;
      act_cnt_r <= '0;
    end else begin
      if (wr && paddr == `STPWM_OFS_CFG) cfg_r <= pwdata[7:0];
      if (wr && paddr == `STPWM_OFS_CMPA) cmpa_r <= pwdata[CNT_W-1:0];
      if (wr && paddr == `STPWM_OFS_ON) on_r <= pwdata[0];
      age_r     <= (wr && paddr == `STPWM_OFS_CFG) ? 2'd0 : ((age_r == 2'd3) ? 2'd3 : age_r + 2'd1);
      act_cnt_r <= (sp && pulse_out == act) ? act_cnt_r + (CNT_W+1)'(timer_tick) : '0;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_APB_RESP: assert property (psel && penable |-> pready && pslverr == !mapped)
    else $error("bad apb answer");
  AST_BAD_RDATA: assert property (psel && penable && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  AST_CAP_NO_DRIVE: assert property (cap |-> pulse_out_en_n)
    else $error("pin driven in capture");
  AST_PWM_DRIVE: assert property (pwm |-> !pulse_out_en_n)
    else $error("pin not driven in pwm");
  AST_PWM_FORCE: assert property (pwm && !cfg_r[5] |-> pulse_out == (cfg_r[4] ? act : !act))
    else $error("forced level wrong");
  AST_SP_LEAD: assert property (sp && wr && paddr == `STPWM_OFS_ON && pwdata[0] && pulse_out != act
    |-> ##[1:4] pulse_out == act) else $error("no pulse after start");
  AST_SP_TRIG: assert property (sp && pulse_out != act && $rose(ext_clock_trigger_pin)
    |-> ##[1:8] pulse_out == act) else $error("no pulse after trigger");
  AST_SP_WIDTH: assert property (sp |-> act_cnt_r <= {1'b0, cmpa_r})
    else $error("pulse outlives compare a");
  AST_SP_IRQ: assert property (sp && timer_irq
    |-> $past(pulse_out) == act || $past(pulse_out, 2) == act || $past(pulse_out, 3) == act)
    else $error("pulse irq without pulse end");
  AST_CAP_IRQ: assert property (cap && on_r && cfg_r[5:4] == STPWM_PIN_00 && $rose(capture_input_pin)
    |-> ##[1:6] timer_irq) else $error("no irq after capture edge");

  cover property (sp && timer_irq);
  cover property (cap && timer_irq);
  cover property (pwm && !sp && $fell(pulse_out));
endmodule

// >>> dv/stpwm_pins.sv
// Pin partner: drives trigger and capture pins, measures active pulse widths.
// Assumes the bench requests edges and states the active output level.
`timescale 1ns/100ps
module stpwm_pins (
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  trig_req,
  input  wire logic  cap_lvl,
  input  wire logic  act_lvl,
  input  wire logic  pulse_out,
  input  wire logic  pulse_out_en_n,
  output logic        ext_clock_trigger_pin,
  output logic        capture_input_pin,
  output logic [16:0] pulse_len,
  output int          pulse_cnt
);
  logic [2:0]  hold_r;
  logic [16:0] run_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r <= '0;
      run_r <= '0;
      pulse_len <= '0;
      pulse_cnt <= 0;
      ext_clock_trigger_pin <= 1'b0;
      capture_input_pin <= 1'b0;
    end else begin
      // Trigger held for several clocks so a synchroniser sees one edge
      hold_r <= trig_req ? 3'd5 : (hold_r != 3'd0 ? hold_r - 3'd1 : 3'd0);
      ext_clock_trigger_pin <= trig_req || hold_r != 3'd0;
      capture_input_pin <= cap_lvl;
      if (!pulse_out_en_n && pulse_out == act_lvl) begin
        run_r <= run_r + 17'd1;
      end else if (run_r != 17'd0) begin
        pulse_len <= run_r;
        pulse_cnt <= pulse_cnt + 1;
        run_r <= '0;
      end
    end
  end
endmodule

// >>> dv/stpwm_timer_test.sv
// Testbench for the standard timer block: APB tasks, pin partner, LFSR values.
// Assumes the zero-wait APB slave of stpwm_timer and the partner in stpwm_pins.sv.
`timescale 1ns/100ps
`include "stpwm_consts.svh"
module stpwm_timer_test;
  import stpwm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        timer_tick, ext_pin, cap_pin, pulse_out, en_n, irq, trig_req, cap_lvl, act_lvl;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v, seed;
  logic [15:0] w;
  logic [16:0] plen;
  int          pcnt, irqs, i0, base, n, num_errors, checks_done;

  stpwm_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_tick(timer_tick), .ext_clock_trigger_pin(ext_pin), .capture_input_pin(cap_pin),
    .pulse_out(pulse_out), .pulse_out_en_n(en_n), .timer_irq(irq));
  stpwm_pins u_pins (.pclk(pclk), .presetn(presetn), .trig_req(trig_req), .cap_lvl(cap_lvl),
    .act_lvl(act_lvl), .pulse_out(pulse_out), .pulse_out_en_n(en_n), .ext_clock_trigger_pin(ext_pin),
    .capture_input_pin(cap_pin), .pulse_len(plen), .pulse_cnt(pcnt));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic end_sim();
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic timeout();
    num_errors++;
    end_sim();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wt, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wt;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      k++;
      if (k > 50) timeout();
      @(posedge pclk);
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic setup(input logic [7:0] cfg, input logic [15:0] a, input logic [7:0] p);
    apb(1'b1, `STPWM_OFS_ON, '0);
    apb(1'b1, `STPWM_OFS_CMPA, 32'(a));
    apb(1'b1, `STPWM_OFS_CMPP, 32'(p));
    apb(1'b1, `STPWM_OFS_CFG, 32'(cfg));
    act_lvl <= cfg[3] ^ cfg[2];
    repeat (3) @(posedge pclk);
    base = pcnt;
    i0   = irqs;
    apb(1'b1, `STPWM_OFS_ON, 32'h1);
  endtask
  task automatic wait_pulses(input int k);
    for (int t = 0; pcnt < base + k; t++) begin
      if (t > 5000) timeout();
      @(posedge pclk);
    end
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) irqs <= 0;
    else if (irq === 1'b1) irqs <= irqs + 1;
  end
  initial begin
    repeat (100000) @(posedge pclk);
    timeout();
  end

  initial begin
    {presetn, psel, penable, pwrite, trig_req, cap_lvl} = '0;
    {paddr, pwdata} = '0;
    {timer_tick, act_lvl} = 2'b11;
    {num_errors, checks_done} = '0;
    seed = 32'h6cb65444;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), '0);
      chk(rd, '0);
      chk(32'(err), 32'(i == 5));
    end
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      timer_tick <= seed[9];
      apb(1'b1, 8'(8 + 4 * (i % 3)), seed);
      apb(1'b0, 8'(8 + 4 * (i % 3)), '0);
      chk(rd, seed & ((i % 3 == 0) ? 32'hffff : ((i % 3 == 1) ? 32'hff : 32'h0)));
    end
    timer_tick <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      setup({4'b1010, 2'(i), 1'b0, seed[0]}, 16'(10 + seed[7:1]), 8'h01);
      wait_pulses(2);
      chk(32'(plen), 32'(10 + seed[7:1]));
    end
    setup(8'b1010_1010, 16'd600, 8'h01);
    wait_pulses(2);
    chk(32'(plen), 32'd256);
    for (int i = 0; i < 2; i++) begin
      setup(8'ha8 | 8'(i << 1), 16'd300, 8'(1 - i));
      repeat (10) @(posedge pclk);
      n = 0;
      repeat (700) begin
        @(posedge pclk);
        n += (pulse_out !== 1'b1);
      end
      chk(n, 0);
    end
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, `STPWM_OFS_CFG, 32'h88 | 32'(i << 4));
      repeat (4) @(posedge pclk);
      chk(32'(pulse_out), 32'(i));
    end
    seed = lfsr(seed);
    w = 16'(5 + seed[4:0]);
    setup({6'b101110, seed[1:0]}, w, seed[15:8]);
    wait_pulses(1);
    chk(32'(plen), 32'(w));
    chk(irqs - i0, 1);
    apb(1'b0, `STPWM_OFS_ON, '0);
    chk(rd, '0);
    apb(1'b0, `STPWM_OFS_COUNT, '0);
    v = rd;
    repeat (5) @(posedge pclk);
    apb(1'b0, `STPWM_OFS_COUNT, '0);
    chk(rd, v);
    trig_req <= 1'b1;
    @(posedge pclk);
    trig_req <= 1'b0;
    wait_pulses(2);
    chk(32'(plen), 32'(w));
    apb(1'b1, `STPWM_OFS_CMPA, 32'h0800);
    apb(1'b1, `STPWM_OFS_ON, 32'h1);
    repeat (20) @(posedge pclk);
    apb(1'b1, `STPWM_OFS_ON, '0);
    repeat (3) @(posedge pclk);
    chk(32'(pulse_out), 32'(!act_lvl));
    chk(irqs - i0, 2);
    for (int m = 0; m < 4; m++) begin
      seed = lfsr(seed);
      setup({2'b01, 2'(m), seed[3:0]}, 16'h00ab, 8'h00);
      repeat (20) @(posedge pclk);
      cap_lvl <= 1'b1;
      repeat (9) @(posedge pclk);
      cap_lvl <= 1'b0;
      repeat (9) @(posedge pclk);
      chk(irqs - i0, (m == 3) ? 0 : ((m == 2) ? 2 : 1));
      apb(1'b0, `STPWM_OFS_CMPA, '0);
      v = rd;
      apb(1'b0, `STPWM_OFS_COUNT, '0);
      chk(32'(v == 32'h00ab), 32'(m == 3));
      chk(32'(rd > 32'd40 && (rd > v || m == 3)), 32'h1);
    end
    setup(8'h70, 16'h0, 8'h01);
    repeat (100) @(posedge pclk);
    i0 = irqs;
    repeat (512) @(posedge pclk);
    chk(irqs - i0, 2);
    setup(8'h70, 16'h0, 8'h00);
    repeat (65600) @(posedge pclk);
    chk(irqs - i0, 1);
    end_sim();
  end
endmodule

bind stpwm_timer stpwm_checker #(.CNT_W(CNT_W), .P_W(P_W)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer_tick(timer_tick), .ext_clock_trigger_pin(ext_clock_trigger_pin),
  .capture_input_pin(capture_input_pin), .pulse_out(pulse_out), .pulse_out_en_n(pulse_out_en_n),
  .timer_irq(timer_irq));

// >>> rtl/stpwm_consts.svh
// Constants for the standard timer PWM, single pulse and capture block.
// Assumes inclusion by bare name from the block's design files.
`ifndef STPWM_CONSTS_SVH
`define STPWM_CONSTS_SVH

// Register byte offsets on APB
`define STPWM_ADDR_W          8
`define STPWM_OFS_ON          8'h00
`define STPWM_OFS_CFG         8'h04
`define STPWM_OFS_CMPA        8'h08
`define STPWM_OFS_CMPP        8'h0c
`define STPWM_OFS_COUNT       8'h10

// Counter-on register field
`define STPWM_ON_BIT          0

// Configuration register fields
`define STPWM_CFG_MODE_HI     7
`define STPWM_CFG_MODE_LO     6
`define STPWM_CFG_PINF_HI     5
`define STPWM_CFG_PINF_LO     4
`define STPWM_CFG_LEVEL_BIT   3
`define STPWM_CFG_INV_BIT     2
`define STPWM_CFG_SWAP_BIT    1
`define STPWM_CFG_CLRSEL_BIT  0
`define STPWM_CFG_W           8

// Reset values
`define STPWM_RST_CFG         8'h00
`define STPWM_RST_CMPA        16'h0000
`define STPWM_RST_CMPP        8'h00
`define STPWM_RST_COUNT       16'h0000

// Compare P is matched against the upper counter byte
`define STPWM_P_LOW_FILL      8'h00
`define STPWM_CNT_ONE         16'h0001
`define STPWM_DUTY_FULL       17'h10000

`endif

// >>> rtl/stpwm_edge_sync.sv
// Two-stage synchroniser with rise and fall pulse detection for one pin.
// Assumes the pin is asynchronous to pclk; pulses are one pclk wide.
`timescale 1ns/100ps
module stpwm_edge_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_in,
  output logic      rise_pulse,
  output logic      fall_pulse
);
  import stpwm_pkg::*;

  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic meta_nxt;
  logic sync_nxt;
  logic prev_nxt;

  always_comb begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  // Edges seen only after the second stage, once per transition
  assign rise_pulse = sync_r & ~prev_r;
  assign fall_pulse = ~sync_r & prev_r;

endmodule

// >>> rtl/stpwm_pkg.sv
// Types shared by the standard timer PWM, single pulse and capture block.
// Assumes no surroundings beyond the design files that import it.
package stpwm_pkg;

  typedef enum logic [1:0] {
    STPWM_MODE_COMPARE = 2'b00,
    STPWM_MODE_CAPTURE = 2'b01,
    STPWM_MODE_PWM     = 2'b10,
    STPWM_MODE_TIMER   = 2'b11
  } stpwm_mode_t;

  typedef enum logic [1:0] {
    STPWM_PIN_00 = 2'b00,
    STPWM_PIN_01 = 2'b01,
    STPWM_PIN_10 = 2'b10,
    STPWM_PIN_11 = 2'b11
  } stpwm_pinf_t;

endpackage

// >>> rtl/stpwm_timer.sv
// Standard timer block: edge-aligned PWM, single pulse and capture modes, APB registers.
// Assumes an APB master on pclk, a timer_tick strobe from the clock prescaler,
// and an interrupt controller that accepts the one-cycle timer_irq pulse.
`timescale 1ns/100ps
`include "stpwm_consts.svh"
module stpwm_timer #(
  parameter int CNT_W = 16,
  parameter int P_W   = 8
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`STPWM_ADDR_W-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     timer_tick,
  input  wire logic                     ext_clock_trigger_pin,
  input  wire logic                     capture_input_pin,
  output logic                          pulse_out,
  output logic                          pulse_out_en_n,
  output logic                          timer_irq
);
  import stpwm_pkg::*;

  // Register state
  logic                     counter_on_r;
  logic                     counter_on_nxt;
  logic [`STPWM_CFG_W-1:0]  cfg_r;
  logic [`STPWM_CFG_W-1:0]  cfg_nxt;
  logic [CNT_W-1:0]         compare_a_value_r;
  logic [CNT_W-1:0]         compare_a_value_nxt;
  logic [P_W-1:0]           compare_p_value_r;
  logic [P_W-1:0]           compare_p_value_nxt;
  logic [CNT_W-1:0]         count_r;
  logic [CNT_W-1:0]         count_nxt;
  logic [31:0]              prdata_r;
  logic [31:0]              prdata_nxt;
  logic                     pulse_out_r;
  logic                     pulse_out_nxt;
  logic                     pulse_out_en_n_r;
  logic                     pulse_out_en_n_nxt;
  logic                     timer_irq_r;
  logic                     timer_irq_nxt;

  // Decoded fields
  stpwm_mode_t              mode_sel;
  stpwm_pinf_t              pin_function;
  logic                     mode_select_hi;
  logic                     mode_select_lo;
  logic                     pin_function_hi;
  logic                     pin_function_lo;
  logic                     output_level_ctl;
  logic                     output_invert;
  logic                     pwm_role_swap;
  logic                     clear_source_select;

  // Bus decode
  logic                     setup_ph;
  logic                     wr_acc;
  logic                     addr_ok;
  logic                     wr_on;
  logic                     wr_cfg;
  logic                     wr_cmpa;
  logic                     wr_cmpp;

  // Timer datapath
  logic                     on_rise;
  logic                     run_step;
  logic [CNT_W-1:0]         a_last;
  logic [CNT_W-1:0]         p_last;
  logic                     a_match;
  logic                     p_match;
  logic [CNT_W:0]           duty_len;
  logic                     pwm_raw;
  logic                     mode_pwm;
  logic                     mode_pulse;
  logic                     mode_cap;
  logic                     trig_rise;
  logic                     cap_rise;
  logic                     cap_fall;
  logic                     cap_hit;
  logic                     active_lvl;
  logic                     out_level;

  // Input synchronisers for the two pins
  stpwm_edge_sync u_trig_sync (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin_in     (ext_clock_trigger_pin),
    .rise_pulse (trig_rise),
    .fall_pulse ()
  );

  stpwm_edge_sync u_cap_sync (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin_in     (capture_input_pin),
    .rise_pulse (cap_rise),
    .fall_pulse (cap_fall)
  );

  assign mode_select_hi      = cfg_r[`STPWM_CFG_MODE_HI];
  assign mode_select_lo      = cfg_r[`STPWM_CFG_MODE_LO];
  assign pin_function_hi     = cfg_r[`STPWM_CFG_PINF_HI];
  assign pin_function_lo     = cfg_r[`STPWM_CFG_PINF_LO];
  assign output_level_ctl    = cfg_r[`STPWM_CFG_LEVEL_BIT];
  assign output_invert       = cfg_r[`STPWM_CFG_INV_BIT];
  assign pwm_role_swap       = cfg_r[`STPWM_CFG_SWAP_BIT];
  assign clear_source_select = cfg_r[`STPWM_CFG_CLRSEL_BIT];
  assign mode_sel            = stpwm_mode_t'({mode_select_hi, mode_select_lo});
  assign pin_function        = stpwm_pinf_t'({pin_function_hi, pin_function_lo});

  // Mode decode; software keeps pin function 11 for single pulse
  assign mode_pwm   = (mode_sel == STPWM_MODE_PWM) && (pin_function != STPWM_PIN_11);
  assign mode_pulse = (mode_sel == STPWM_MODE_PWM) && (pin_function == STPWM_PIN_11);
  assign mode_cap   = (mode_sel == STPWM_MODE_CAPTURE);

  // APB decode: zero wait states, error on unmapped offsets
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;
  assign addr_ok  = (paddr == `STPWM_OFS_ON) || (paddr == `STPWM_OFS_CFG) ||
                    (paddr == `STPWM_OFS_CMPA) || (paddr == `STPWM_OFS_CMPP) ||
                    (paddr == `STPWM_OFS_COUNT);
  assign wr_on    = wr_acc && (paddr == `STPWM_OFS_ON);
  assign wr_cfg   = wr_acc && (paddr == `STPWM_OFS_CFG);
  assign wr_cmpa  = wr_acc && (paddr == `STPWM_OFS_CMPA);
  assign wr_cmpp  = wr_acc && (paddr == `STPWM_OFS_CMPP);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addr_ok;
  assign prdata   = prdata_r;

  // Counter-on edge and stepping
  // The rise is taken from the next value, so the count is already zero at the
  // edge where counter-on goes high and the first period or pulse is exact
  assign on_rise  = counter_on_nxt & ~counter_on_r;
  assign run_step = counter_on_r & timer_tick;

  // Last count of a compare window; a zero setting gives the full 65536 span
  assign a_last  = compare_a_value_r - `STPWM_CNT_ONE;
  // Compare P sees only the upper byte, so its windows are multiples of 256
  assign p_last  = {compare_p_value_r, `STPWM_P_LOW_FILL} - `STPWM_CNT_ONE;
  // Matches are qualified by a step, so a stopped counter raises none
  assign a_match = run_step && (count_r == a_last);
  assign p_match = run_step && (count_r == p_last);

  // Duty length from the compare that is not the period
  always_comb begin
    duty_len = {1'b0, compare_a_value_r};
    if (pwm_role_swap) begin
      if (compare_p_value_r == {P_W{1'b0}}) begin
        duty_len = `STPWM_DUTY_FULL;
      end else begin
        duty_len = {1'b0, compare_p_value_r, `STPWM_P_LOW_FILL};
      end
    end
  end

  // Duty at or above the period keeps the comparison true all period
  assign pwm_raw = ({1'b0, count_r} < duty_len);

  // Capture edge selection
  always_comb begin
    cap_hit = 1'b0;
    unique case (pin_function)
      STPWM_PIN_00: cap_hit = cap_rise;
      STPWM_PIN_01: cap_hit = cap_fall;
      STPWM_PIN_10: cap_hit = cap_rise | cap_fall;
      STPWM_PIN_11: cap_hit = 1'b0;
    endcase
  end

  // Register writes and counter-on control
  // Later assignments take priority over earlier ones
  always_comb begin
    cfg_nxt             = cfg_r;
    compare_p_value_nxt = compare_p_value_r;
    compare_a_value_nxt = compare_a_value_r;
    counter_on_nxt      = counter_on_r;
    if (wr_cfg) begin
      cfg_nxt = pwdata[`STPWM_CFG_W-1:0];
    end
    if (wr_cmpp) begin
      compare_p_value_nxt = pwdata[P_W-1:0];
    end
    if (wr_cmpa) begin
      compare_a_value_nxt = pwdata[CNT_W-1:0];
    end
    // Capture beats a same-cycle software write
    if (mode_cap && counter_on_r && cap_hit) begin
      compare_a_value_nxt = count_r;
    end
    if (wr_on) begin
      counter_on_nxt = pwdata[`STPWM_ON_BIT];
    end
    // Compare A ends the pulse by clearing counter-on
    if (mode_pulse && a_match) begin
      counter_on_nxt = 1'b0;
    end
    // External trigger sets counter-on and wins over any clear
    if (mode_pulse && trig_rise && !counter_on_r) begin
      counter_on_nxt = 1'b1;
    end
  end

  // Counter
  // A stopped counter keeps its value until the next counter-on rise
  always_comb begin
    count_nxt = count_r;
    if (on_rise) begin
      // Counting restarts from zero on every counter-on rise
      count_nxt = `STPWM_RST_COUNT;
    end else if (run_step) begin
      count_nxt = count_r + `STPWM_CNT_ONE;
      if (mode_pwm) begin
        // Period comparator chosen by role swap alone; clear select ignored
        if (pwm_role_swap ? a_match : p_match) begin
          count_nxt = `STPWM_RST_COUNT;
        end
      end else if (mode_cap) begin
        // Compare P bounds the free-running count
        if (p_match) begin
          count_nxt = `STPWM_RST_COUNT;
        end
      end else if (mode_pulse) begin
        // No clear at pulse end; compare P and swap unused
        count_nxt = count_r + `STPWM_CNT_ONE;
      end
    end
  end

  // Interrupt request pulse
  always_comb begin
    timer_irq_nxt = 1'b0;
    if (mode_pwm) begin
      timer_irq_nxt = a_match | p_match;
    end else if (mode_pulse) begin
      timer_irq_nxt = a_match;
    end else if (mode_cap) begin
      timer_irq_nxt = p_match | (counter_on_r & cap_hit);
    end
  end

  // Output pin
  assign active_lvl = output_level_ctl;
  always_comb begin
    out_level          = ~active_lvl;
    pulse_out_en_n_nxt = 1'b1;
    if (mode_pwm) begin
      pulse_out_en_n_nxt = 1'b0;
      // Forced levels leave the counter and comparators running
      unique case (pin_function)
        STPWM_PIN_00: out_level = ~active_lvl;
        STPWM_PIN_01: out_level = active_lvl;
        STPWM_PIN_10: out_level = (counter_on_r & pwm_raw) ? active_lvl : ~active_lvl;
        STPWM_PIN_11: out_level = ~active_lvl;
      endcase
    end else if (mode_pulse) begin
      pulse_out_en_n_nxt = 1'b0;
      // Pulse is active exactly while counter-on is high
      out_level = counter_on_nxt ? active_lvl : ~active_lvl;
    end
    // Capture and other modes leave the pin undriven
    pulse_out_nxt = pulse_out_en_n_nxt ? 1'b0 : (out_level ^ output_invert);
  end

  // Read data captured in the setup phase
  always_comb begin
    prdata_nxt = prdata_r;
    if (setup_ph) begin
      prdata_nxt = 32'h0000_0000;
      if (paddr == `STPWM_OFS_ON) begin
        prdata_nxt[`STPWM_ON_BIT] = counter_on_r;
      end else if (paddr == `STPWM_OFS_CFG) begin
        prdata_nxt[`STPWM_CFG_W-1:0] = cfg_r;
      end else if (paddr == `STPWM_OFS_CMPA) begin
        prdata_nxt[CNT_W-1:0] = compare_a_value_r;
      end else if (paddr == `STPWM_OFS_CMPP) begin
        prdata_nxt[P_W-1:0] = compare_p_value_r;
      end else if (paddr == `STPWM_OFS_COUNT) begin
        prdata_nxt[CNT_W-1:0] = count_r;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_on_r      <= 1'b0;
      cfg_r             <= `STPWM_RST_CFG;
      compare_a_value_r <= `STPWM_RST_CMPA;
      compare_p_value_r <= `STPWM_RST_CMPP;
      count_r           <= `STPWM_RST_COUNT;
      prdata_r          <= 32'h0000_0000;
      pulse_out_r       <= 1'b0;
      pulse_out_en_n_r  <= 1'b1;
      timer_irq_r       <= 1'b0;
    end else begin
      counter_on_r      <= counter_on_nxt;
      cfg_r             <= cfg_nxt;
      compare_a_value_r <= compare_a_value_nxt;
      compare_p_value_r <= compare_p_value_nxt;
      count_r           <= count_nxt;
      prdata_r          <= prdata_nxt;
      pulse_out_r       <= pulse_out_nxt;
      pulse_out_en_n_r  <= pulse_out_en_n_nxt;
      timer_irq_r       <= timer_irq_nxt;
    end
  end

  assign pulse_out      = pulse_out_r;
  assign pulse_out_en_n = pulse_out_en_n_r;
  assign timer_irq      = timer_irq_r;

endmodule
